// file: verilog/sep_pkg.sv
`default_nettype none
package sep_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_NS       = 5;
   localparam int SCL_NS       = 80;
   localparam int QTR_CYC      = SCL_NS / (4 * CLK_NS);
   localparam int PROG_TIME_NS = 5000;
   localparam int PROG_CYC     = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUSY_W       = 24;
   localparam int MAX_POLLS    = 255;
   // ----------------------------------------------------------------
   // Memory layout and select byte
   // ----------------------------------------------------------------
   localparam int ADDR_W          = 12;
   localparam int ID_W            = 5;
   localparam int ARRAY_BYTES     = 4096;
   localparam int ID_BYTES        = 32;
   localparam int ID_LOCK_HI_BIT  = 2;
   localparam logic [3:0] TYPE_ARRAY = 4'ha;
   localparam logic [3:0] TYPE_ID    = 4'hb;
   localparam logic       RW_READ    = 1'b1;
   localparam logic [7:0] ERASED     = 8'hff;
   localparam logic [3:0] ACK_BIT    = 4'h8;
   localparam logic [3:0] ACK_DONE   = 4'h9;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {OP_CUR = 2'h0, OP_RAND = 2'h1, OP_WRITE = 2'h2,
                             OP_PROBE = 2'h3} sep_op_t;
   typedef enum logic [2:0] {D_IDLE = 3'h0, D_SEL = 3'h1, D_AHI = 3'h3, D_ALO = 3'h2,
                             D_DIN = 3'h6, D_RD = 3'h7} sep_dst_t;
   typedef enum logic [2:0] {H_IDLE = 3'h0, H_START = 3'h1, H_TX = 3'h3, H_RX = 3'h2,
                             H_STOP = 3'h6} sep_hst_t;
   typedef enum logic [2:0] {S_SEL = 3'h0, S_AHI = 3'h1, S_ALO = 3'h2, S_DATA = 3'h3,
                             S_RSEL = 3'h4, S_READ = 3'h5} sep_seq_t;
endpackage
`default_nettype wire

// file: verilog/sep_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sep_link_if;
   logic scl;          // Serial clock, driven by the master
   logic host_sda_oe;  // Master pulls data low
   logic dev_sda_oe;   // Device pulls data low
   wire  sda;          // Resolved open-drain data level
   assign sda = ~(host_sda_oe | dev_sda_oe);
   modport host (output scl, output host_sda_oe, input sda);
   modport dev  (input scl, input sda, output dev_sda_oe);
endinterface
`default_nettype wire

// file: verilog/sep_dev.sv
// How it works
// - Busy programming cycle ignores bus traffic
// - Busy device leaves select unacknowledged
// - Ready device acknowledges polling select byte
// - Reads ignore write protect level
// - Address counter advances after each read
// - Random read: dummy write, restart, read
// - Master repeats identical seven select bits
// - Current read outputs byte at counter
// - Master acknowledge continues sequential read
// - Counter wraps past top to zero
// - Type 1011b reads ID page offset
// - Master keeps ID reads inside page
// - Lock probe: data ack means unlocked
// - Start mid command resets protocol logic
// - Start then Stop returns to standby
// - Master NoAck ends read, standby
// - Delivered content reads all ones
// - Only types 1010b, 1011b acknowledged
// - Chip address must match select pins
// - Last select bit gives direction
// - Two address bytes, high first, acknowledged
`timescale 1ns/1ps
`default_nettype none
module sep_dev #(
   parameter int PROG_CYCLES = sep_pkg::PROG_CYC
) (
   input  wire logic sys_clk,               // System clock
   input  wire logic reset_n,               // Synchronous reset, active low
   sep_link_if.dev   link,                  // Two-wire bus
   input  wire logic chip_select_bit0,      // Chip address pin 0
   input  wire logic chip_select_bit1,      // Chip address pin 1
   input  wire logic chip_select_bit2,      // Chip address pin 2
   input  wire logic write_protect_input,   // High inhibits array writes
   input  wire logic id_page_lock_command,  // High: ID page locked
   output logic      prog_busy              // Programming cycle running
);
   import sep_pkg::*;

   typedef struct packed {
      logic [1:0]        scl_sy;
      logic [1:0]        sda_sy;
      logic [4:0]        pin_s1;
      logic [4:0]        pin_s2;
      logic              scl_q;
      logic              sda_q;
      sep_dst_t          st;
      sep_dst_t          nxt;
      logic [3:0]        cnt;
      logic [7:0]        sh;
      logic [7:0]        dout;
      logic [7:0]        ahi;
      logic [7:0]        wdat;
      logic [ADDR_W-1:0] addr;
      logic              id;
      logic              oe;
      logic              mack;
      logic              wr_pend;
      logic              busy;
      logic [BUSY_W-1:0] bcnt;
   } sep_dev_st_t;

   sep_dev_st_t s;
   sep_dev_st_t n;
   logic [7:0]  mem [ARRAY_BYTES];
   logic [7:0]  id_mem [ID_BYTES];
   logic        mem_we;
   logic        id_we;
   logic        scl;
   logic        sda;
   logic        rise;
   logic        fall;
   logic        start;
   logic        stop;
   logic        ok;
   logic [7:0]  rbyte;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // erased delivery content
   initial begin
      for (int i = 0; i < ARRAY_BYTES; i++) begin
         mem[i] = ERASED;
      end
      for (int i = 0; i < ID_BYTES; i++) begin
         id_mem[i] = ERASED;
      end
   end

   // Committed byte lands after the Stop that ends a write
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         mem[s.addr] <= s.wdat;
      end
      if (id_we) begin
         id_mem[s.addr[ID_W-1:0]] <= s.wdat;
      end
   end

   // ----------------------------------------------------------------
   // Protocol engine
   // ----------------------------------------------------------------
   // Next state of the whole device
   always_comb begin
      n      = s;
      mem_we = 1'b0;
      id_we  = 1'b0;
      ok     = 1'b0;
      n.scl_sy = {s.scl_sy[0], link.scl};
      n.sda_sy = {s.sda_sy[0], link.sda};
      n.pin_s1 = {id_page_lock_command, write_protect_input,
                  chip_select_bit2, chip_select_bit1, chip_select_bit0};
      n.pin_s2 = s.pin_s1;
      scl      = s.scl_sy[1];
      sda      = s.sda_sy[1];
      n.scl_q  = scl;
      n.sda_q  = sda;
      rise     = scl & ~s.scl_q;
      fall     = ~scl & s.scl_q;
      start    = scl & s.scl_q & s.sda_q & ~sda;
      stop     = scl & s.scl_q & ~s.sda_q & sda;
      rbyte    = s.id ? id_mem[s.addr[ID_W-1:0]] : mem[s.addr];
      if (s.busy) begin
         if (s.bcnt == BUSY_W'(PROG_CYCLES - 1)) begin
            n.busy = 1'b0;
         end else begin
            n.bcnt = s.bcnt + 1'b1;
         end
      end
      if (stop) begin
         n.st      = D_IDLE;
         n.oe      = 1'b0;
         n.wr_pend = 1'b0;
         // Stop in the slot right after the data ack: its rise already counted one bit
         if (s.st == D_DIN && s.cnt == 4'h1 && s.wr_pend) begin
            mem_we = ~s.id;
            id_we  = s.id & ~s.ahi[ID_LOCK_HI_BIT];
            n.busy = 1'b1;
            n.bcnt = '0;
         end
      end else if (start) begin
         n.st      = D_SEL;
         n.cnt     = 4'h0;
         n.oe      = 1'b0;
         n.wr_pend = 1'b0;
      end else if (s.st != D_IDLE && rise) begin
         if (s.cnt < ACK_BIT) begin
            n.cnt  = s.cnt + 1'b1;
            n.sh   = {s.sh[6:0], sda};
            n.dout = {s.dout[6:0], 1'b1};
         end else if (s.cnt == ACK_BIT) begin
            n.cnt = ACK_DONE;
            if (s.st == D_RD) begin
               n.mack = ~sda;
               n.addr = s.addr + 1'b1;
            end
         end
      end else if (s.st != D_IDLE && fall) begin
         if (s.st == D_RD) begin
            if (s.cnt < ACK_BIT) begin
               n.oe = ~s.dout[7];
            end else if (s.cnt == ACK_BIT) begin
               n.oe = 1'b0;
            end else if (s.mack) begin
               n.dout = rbyte;
               n.oe   = ~rbyte[7];
               n.cnt  = 4'h0;
            end else begin
               n.oe = 1'b0;
               n.st = D_IDLE;
            end
         end else if (s.cnt == ACK_BIT) begin
            case (s.st)
               D_SEL: begin
                  ok    = (s.sh[7:4] == TYPE_ARRAY || s.sh[7:4] == TYPE_ID) &&
                          s.sh[3:1] == s.pin_s2[2:0] && ~s.busy;
                  n.id  = (s.sh[7:4] == TYPE_ID);
                  n.nxt = ~ok ? D_IDLE : (s.sh[0] == RW_READ ? D_RD : D_AHI);
               end
               D_AHI: begin
                  ok    = 1'b1;
                  n.ahi = s.sh;
                  n.nxt = D_ALO;
               end
               D_ALO: begin
                  ok     = 1'b1;
                  n.addr = {s.ahi[ADDR_W-9:0], s.sh};
                  n.nxt  = D_DIN;
               end
               default: begin
                  ok        = s.id ? ~s.pin_s2[4] : ~s.pin_s2[3];
                  n.wdat    = s.sh;
                  n.wr_pend = ok;
                  n.nxt     = D_DIN;
               end
            endcase
            n.oe = ok;
         end else if (s.cnt == ACK_DONE) begin
            n.cnt = 4'h0;
            n.st  = s.nxt;
            if (s.nxt == D_RD) begin
               n.dout = rbyte;
               n.oe   = ~rbyte[7];
            end else begin
               n.oe = 1'b0;
            end
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign link.dev_sda_oe = s.oe;
   assign prog_busy       = s.busy;
endmodule
`default_nettype wire

// file: verilog/sep_host.sv
`timescale 1ns/1ps
`default_nettype none
module sep_host #(
   parameter int QTR   = sep_pkg::QTR_CYC,
   parameter int POLLS = sep_pkg::MAX_POLLS
) (
   input  wire logic             sys_clk,    // System clock
   input  wire logic             reset_n,    // Synchronous reset, active low
   sep_link_if.host              link,       // Two-wire bus
   input  wire logic             cmd_valid,  // Command offered
   output logic                  cmd_ready,  // Idle, command taken
   input  wire sep_pkg::sep_op_t cmd_op,     // Operation
   input  wire logic             cmd_id,     // Target ID page
   input  wire logic [2:0]       cmd_cs,     // Chip address
   input  wire logic [15:0]      cmd_addr,   // Byte address
   input  wire logic [7:0]       cmd_len,    // Bytes to read, 0 means 1
   input  wire logic [7:0]       cmd_wdata,  // Write or probe byte
   output logic [7:0]            rd_data,    // Read byte
   output logic                  rd_valid,   // Read byte valid
   input  wire logic             rd_ready,   // Consumer takes byte
   output logic                  done,       // Command finished pulse
   output logic                  acked       // Last command acknowledged
);
   import sep_pkg::*;

   typedef struct packed {
      logic [1:0]  sda_sy;
      logic [7:0]  div;
      logic [1:0]  ph;
      sep_hst_t    st;
      sep_seq_t    seq;
      logic [3:0]  bitn;
      logic [7:0]  tx;
      logic [7:0]  rx;
      sep_op_t     op;
      logic        id;
      logic [2:0]  cs;
      logic [15:0] addr;
      logic [7:0]  wdat;
      logic [7:0]  left;
      logic [7:0]  polls;
      logic        nak;
      logic        fin;
      logic        scl;
      logic        oe;
      logic        rdy;
      logic        done;
      logic        acked;
      logic        hv;
      logic        sv;
      logic [7:0]  head;
      logic [7:0]  skid;
   } sep_host_st_t;

   sep_host_st_t s;
   sep_host_st_t n;
   logic         sda;
   logic         stall;
   logic         tick;
   logic         push;

   // Select byte for this command
   function automatic logic [7:0] sel_byte(input logic id, input logic [2:0] cs,
                                           input logic rw);
      sel_byte = {id ? TYPE_ID : TYPE_ARRAY, cs, rw};
   endfunction

   // ----------------------------------------------------------------
   // Sequencer, bit engine and two-entry read buffer
   // ----------------------------------------------------------------
   always_comb begin
      n        = s;
      n.done   = 1'b0;
      push     = 1'b0;
      n.sda_sy = {s.sda_sy[0], link.sda};
      sda      = s.sda_sy[1];
      // Consumer side of the buffer
      if (s.hv && rd_ready) begin
         n.head = s.skid;
         n.hv   = s.sv;
         n.sv   = 1'b0;
      end
      // Full buffer holds the clock low before the next byte
      stall = s.st == H_RX && s.bitn == 4'h0 && s.ph == 2'h0 && s.hv && s.sv;
      tick  = 1'b0;
      if (s.st != H_IDLE && !stall) begin
         tick  = (s.div == 8'(QTR - 1));
         n.div = tick ? 8'h0 : s.div + 1'b1;
      end
      if (s.st == H_IDLE) begin
         n.rdy = 1'b1;
         if (cmd_valid && s.rdy) begin
            n.rdy   = 1'b0;
            n.op    = cmd_op;
            n.id    = cmd_id;
            n.cs    = cmd_cs;
            n.addr  = cmd_addr;
            n.wdat  = cmd_wdata;
            n.left  = (cmd_len == 8'h0) ? 8'h1 : cmd_len;
            n.polls = 8'h0;
            n.fin   = 1'b0;
            n.seq   = S_SEL;
            n.ph    = 2'h0;
            n.st    = H_START;
            n.tx    = sel_byte(cmd_id, cmd_cs, cmd_op == OP_CUR);
         end
      end else if (tick) begin
         n.ph = s.ph + 1'b1;
         case (s.ph)
            2'h0: begin
               if (s.st == H_START) n.oe = 1'b0;
               else if (s.st == H_STOP) n.oe = 1'b1;
               else if (s.st == H_TX) n.oe = (s.bitn < ACK_BIT) ? ~s.tx[7] : 1'b0;
               else n.oe = (s.bitn == ACK_BIT) ? (s.left > 8'h1) : 1'b0;
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
               if (s.st == H_START) n.oe = 1'b1;
               else if (s.st == H_STOP) n.oe = 1'b0;
               else if (s.st == H_TX) n.nak = sda;
               else if (s.bitn < ACK_BIT) n.rx = {s.rx[6:0], sda};
            end
            default: begin
               if (s.st != H_STOP) n.scl = 1'b0;
               n.bitn = s.bitn + 1'b1;
               case (s.st)
                  H_START: begin
                     n.bitn = 4'h0;
                     n.st   = s.fin ? H_STOP : H_TX;
                  end
                  H_STOP: begin
                     n.st   = H_IDLE;
                     n.done = 1'b1;
                  end
                  H_RX: begin
                     push = (s.bitn == 4'h7);
                     if (s.bitn == ACK_BIT) begin
                        n.left = s.left - 1'b1;
                        n.bitn = 4'h0;
                        if (s.left == 8'h1) n.st = H_STOP;
                     end
                  end
                  default: begin
                     if (s.bitn < ACK_BIT) begin
                        n.tx = {s.tx[6:0], 1'b0};
                     end else begin
                        n.bitn = 4'h0;
                        case (s.seq)
                           S_SEL: begin
                              if (s.nak) begin
                                 n.polls = s.polls + 1'b1;
                                 n.st    = (s.polls == 8'(POLLS - 1)) ? H_STOP : H_START;
                                 n.acked = 1'b0;
                                 n.tx    = sel_byte(s.id, s.cs, s.op == OP_CUR);
                              end else if (s.op == OP_CUR) begin
                                 n.acked = 1'b1;
                                 n.seq   = S_READ;
                                 n.st    = H_RX;
                              end else begin
                                 n.seq = S_AHI;
                                 n.tx  = s.addr[15:8];
                              end
                           end
                           S_AHI: begin
                              n.seq = S_ALO;
                              n.tx  = s.addr[7:0];
                           end
                           S_ALO: begin
                              if (s.op == OP_RAND) begin
                                 n.seq = S_RSEL;
                                 n.st  = H_START;
                                 n.tx  = sel_byte(s.id, s.cs, RW_READ);
                              end else begin
                                 n.seq = S_DATA;
                                 n.tx  = s.wdat;
                              end
                           end
                           S_DATA: begin
                              n.acked = ~s.nak;
                              n.fin   = (s.op == OP_PROBE);
                              n.st    = (s.op == OP_PROBE) ? H_START : H_STOP;
                           end
                           default: begin
                              n.acked = ~s.nak;
                              n.seq   = S_READ;
                              n.st    = s.nak ? H_STOP : H_RX;
                           end
                        endcase
                     end
                  end
               endcase
            end
         endcase
      end
      // Producer side of the buffer
      if (push) begin
         if (!n.hv) begin
            n.head = s.rx;
            n.hv   = 1'b1;
         end else begin
            n.skid = s.rx;
            n.sv   = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         s        <= '0;
         s.scl    <= 1'b1;
         s.sda_sy <= 2'b11;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign link.scl         = s.scl;
   assign link.host_sda_oe = s.oe;
   assign cmd_ready        = s.rdy;
   assign rd_data          = s.head;
   assign rd_valid         = s.hv;
   assign done             = s.done;
   assign acked            = s.acked;
endmodule
`default_nettype wire

// file: verification/sep_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sep_checker #(
   parameter int PROG_CYCLES = 20
) (
   input wire logic sys_clk,     // System clock
   input wire logic reset_n,     // Synchronous reset, active low
   input wire logic scl,         // Serial clock level
   input wire logic host_sda_oe, // Master pulls data low
   input wire logic dev_sda_oe,  // Device pulls data low
   input wire logic sda,         // Resolved data level
   input wire logic prog_busy    // Programming cycle running
);
   localparam int BUSY_MAX = PROG_CYCLES + 4;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // ----------------------------------------------------------------
   // Bus and busy-interval checks
   // ----------------------------------------------------------------
   chk_busy_silent: assert property (
      prog_busy |-> !dev_sda_oe) else $error("device drives data while busy");
   chk_busy_min_len: assert property (
      $rose(prog_busy) |-> prog_busy[*8]) else $error("busy interval too short");
   chk_busy_max_len: assert property (
      $rose(prog_busy) |-> ##[1:BUSY_MAX] !prog_busy) else $error("busy interval too long");
   chk_busy_after_stop: assert property (
      $rose(prog_busy) |-> scl && sda) else $error("busy started outside a stop");
   chk_dev_data_low: assert property (
      $changed(dev_sda_oe) |-> !scl) else $error("device data moved while clock high");
   chk_scl_high_time: assert property (
      $rose(scl) |-> scl[*8]) else $error("clock high phase too short");
   chk_scl_low_time: assert property (
      $fell(scl) |-> !scl[*8]) else $error("clock low phase too short");
   chk_frame_dev_free: assert property (
      scl && $changed(host_sda_oe) |-> !dev_sda_oe) else $error("start or stop while device drives");
endmodule
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sep_pkg::*;
   localparam int PROG = 400;
   typedef struct {
      sep_op_t     op;
      logic        id;
      logic [2:0]  cs;
      logic [15:0] addr;
      logic [7:0]  len;
      logic [7:0]  wd;
      logic        lk;
      logic        ack;
   } sep_row_t;
   logic        sys_clk = 1'h0;
   logic        reset_n = 1'h0;
   logic        cmd_valid = 1'h0;
   logic        rd_ready = 1'h1;
   logic        cmd_id = 1'h0;
   logic        wp = 1'h0;
   logic        lk = 1'h0;
   logic [2:0]  pins = 3'h5;
   logic [2:0]  cmd_cs = 3'h5;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0]  cmd_len = 8'h01;
   logic [7:0]  cmd_wdata = 8'h00;
   sep_op_t     cmd_op = OP_CUR;
   logic        cmd_ready, rd_valid, done, acked, prog_busy;
   logic [7:0]  rd_data;
   logic [7:0]  arr [4096];
   logic [7:0]  idp [32];
   logic [11:0] ctr = 12'h000;
   int          n_fail = 0;
   int          total_checks = 0;
   sep_row_t    rows [12] = '{
      '{OP_RAND, '0, 3'h5, 16'h0010, 8'h01, 8'h00, '0, '1},
      '{OP_WRITE, '0, 3'h5, 16'h0000, 8'h01, 8'ha5, '0, '1},
      '{OP_WRITE, '0, 3'h5, 16'h0021, 8'h01, 8'h3c, '0, '1},
      '{OP_RAND, '0, 3'h5, 16'h0021, 8'h01, 8'h00, '0, '1},
      '{OP_CUR, '0, 3'h5, 16'h0000, 8'h02, 8'h00, '0, '1},
      '{OP_RAND, '0, 3'h5, 16'h0ffe, 8'h04, 8'h00, '0, '1},
      '{OP_WRITE, '1, 3'h5, 16'hf3e3, 8'h01, 8'h77, '0, '1},
      '{OP_RAND, '1, 3'h5, 16'h1fe3, 8'h02, 8'h00, '0, '1},
      '{OP_PROBE, '1, 3'h5, 16'h0403, 8'h01, 8'h11, '0, '1},
      '{OP_PROBE, '1, 3'h5, 16'h0403, 8'h01, 8'h11, '1, '0},
      '{OP_RAND, '1, 3'h5, 16'h0003, 8'h01, 8'h00, '0, '1},
      '{OP_RAND, '0, 3'h2, 16'h0010, 8'h01, 8'h00, '0, '0}};
   // Clock and bus
   always #2.5 sys_clk = ~sys_clk;
   sep_link_if link ();
   sep_dev #(.PROG_CYCLES(PROG)) i_sep_dev (.sys_clk(sys_clk), .reset_n(reset_n), .link(link),
      .chip_select_bit0(pins[0]), .chip_select_bit1(pins[1]), .chip_select_bit2(pins[2]),
      .write_protect_input(wp), .id_page_lock_command(lk), .prog_busy(prog_busy));
   sep_host #(.QTR(4), .POLLS(8)) i_sep_host (.sys_clk(sys_clk), .reset_n(reset_n),
      .link(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_id(cmd_id), .cmd_cs(cmd_cs), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
      .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .done(done), .acked(acked));
   sep_checker #(.PROG_CYCLES(PROG)) i_sep_checker (.sys_clk(sys_clk), .reset_n(reset_n),
      .scl(link.scl), .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
      .sda(link.sda), .prog_busy(prog_busy));
   // ----------------------------------------------------------------
   // Compare and closing tasks
   // ----------------------------------------------------------------
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_bit(input logic got, input logic exp);
      cmp_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One command through the host, bytes gathered and compared with the model
   task automatic run(input sep_row_t r, input int stall);
      logic [7:0]  q [$];
      logic [11:0] base;
      logic [11:0] a;
      int          i;
      int          n;
      @(posedge sys_clk);
      #1;
      cmd_op = r.op;
      {cmd_id, cmd_cs, cmd_addr, cmd_len, cmd_wdata, lk} =
         {r.id, r.cs, r.addr, r.len, r.wd, r.lk};
      cmd_valid = 1'h1;
      for (i = 0; i < 200 && cmd_ready !== 1'h1; i++) begin
         @(posedge sys_clk);
         #1;
      end
      @(posedge sys_clk);
      #1;
      cmd_valid = 1'h0;
      for (i = 0; i < 20000 && done !== 1'h1; i++) begin
         if (stall > 0 && i == stall - 1) begin
            cmp_bit(rd_valid, 1'h1);
            cmp_bit(link.scl, 1'h0);
         end
         if (i == stall) rd_ready = 1'h1;
         if (rd_valid && rd_ready) q.push_back(rd_data);
         @(posedge sys_clk);
         #1;
      end
      cmp_bit(done, 1'h1);
      cmp_bit(acked, r.ack);
      if (r.op == OP_WRITE && r.ack && !r.id) begin
         arr[r.addr[11:0]] = r.wd;
         ctr = r.addr[11:0] + 12'h001;
      end
      if (r.op == OP_WRITE && r.ack && r.id && !r.addr[10]) idp[r.addr[4:0]] = r.wd;
      n = (r.ack && (r.op == OP_CUR || r.op == OP_RAND)) ? int'(r.len) : 0;
      base = (r.op == OP_RAND) ? r.addr[11:0] : ctr;
      cmp_byte(8'(q.size()), 8'(n));
      for (i = 0; i < n; i++) begin
         a = base + 12'(i);
         cmp_byte(q[i], r.id ? idp[a[4:0]] : arr[a]);
      end
      if (n > 0) ctr = base + 12'(n);
   endtask
   // Watchdog
   initial begin
      repeat (90000) @(posedge sys_clk);
      n_fail++;
      end_of_test();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      foreach (arr[i]) arr[i] = ERASED;
      foreach (idp[i]) idp[i] = ERASED;
      repeat (3) @(posedge sys_clk);
      #1;
      cmp_byte({link.scl, link.host_sda_oe, link.dev_sda_oe, prog_busy, cmd_ready,
         rd_valid, done, acked}, 8'h80);
      reset_n = 1'h1;
      foreach (rows[k]) run(rows[k], 0);
      wp = 1'h1;
      run('{OP_WRITE, '0, 3'h5, 16'h0ffd, 8'h01, 8'h5a, '0, '0}, 0);
      rd_ready = 1'h0;
      run('{OP_RAND, '0, 3'h5, 16'h0ffc, 8'h06, 8'h00, '0, '1}, 1500);
      end_of_test();
   end
endmodule
`default_nettype wire
